// File: bench/qec_chk.sv
// Port checker for the encoder counter.
// Assumes it is bound onto qec_counter with CW handed on.
`timescale 1ns/1ns
`default_nettype none
module qec_chk #(parameter CW = 32) (
   input wire logic          ref_clk_i,
   input wire logic          rst_i,
   input wire logic [3:0]    reg_addr_i,
   input wire logic [31:0]   reg_wdata_i,
   input wire logic          reg_wr_i,
   input wire logic          reg_rd_i,
   input wire logic [31:0]   reg_rdata_o,
   input wire logic [CW-1:0] count_o,
   input wire logic [CW-1:0] raw_count_o,
   input wire logic          index_seen_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   logic       hold;
   logic [1:0] clr;
   // The clear may land one cycle late, so two cycles of history are kept.
   always @(posedge ref_clk_i) begin
      clr <= {clr[0], reg_wr_i && reg_addr_i == 4'h3 && reg_wdata_i[0]};
      if (rst_i) hold <= 1'b0;
      else if (reg_wr_i && reg_addr_i == 4'h0) hold <= reg_wdata_i[0];
   end
   sequence rd_at(logic [3:0] a);
      reg_rd_i && reg_addr_i == a;
   endsequence
   AST_HOLD_ZERO: assert property (hold && $past(hold) |-> count_o == 0)
      else $error("count moved under reset");
   AST_RAW_STEP: assert property (raw_count_o + 1'b1 - $past(raw_count_o) <= 2)
      else $error("raw total jumped");
   AST_CNT_STEP: assert property (count_o == 0 || count_o + 1'b1 - $past(count_o) <= 2)
      else $error("count jumped");
   AST_CNT_RAW: assert property ($changed(count_o) && count_o != 0 |->
      count_o - $past(count_o) == raw_count_o - $past(raw_count_o)) else $error("count off raw");
   AST_RD_CNT: assert property (rd_at(4'h1) |=> reg_rdata_o == $past(count_o))
      else $error("count read wrong");
   AST_RD_RAW: assert property (rd_at(4'h2) |=> reg_rdata_o == $past(raw_count_o))
      else $error("raw read wrong");
   AST_RD_IDLE: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 0)
      else $error("read data outside read");
   AST_SEEN_CLR: assert property ($fell(index_seen_o) |-> |clr)
      else $error("index flag dropped alone");
endmodule // qec_chk
bind qec_counter qec_chk #(.CW(CW)) u_chk (.ref_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i,
   .reg_wr_i, .reg_rd_i, .reg_rdata_o, .count_o, .raw_count_o, .index_seen_o);
`default_nettype wire

// File: bench/qec_counter_test.sv
// Self-checking bench for the encoder counter.
// Assumes the encoder model and the bound checker are compiled alongside.
`timescale 1ns/1ns
`default_nettype none
module qec_counter_test;
   typedef struct {logic [7:0] c; int dir; int n; int hi; int e;} qec_row_t;
   qec_row_t rows[9] = '{'{8'h40, 1, 4, 0, 4}, '{8'h00, -1, 7, 0, -7}, '{8'h40, -1, 1, 0, -1},
      '{8'h60, 1, 3, 20, 3}, '{8'h20, 0, 2, 8, -2}, '{8'h60, 1, 1, 12, 0},
      '{8'h60, 1, 1, 20, 1}, '{8'h20, 1, 1, 2, 0}, '{8'h20, 1, 1, 5, 1}};
   logic [9:0]  ix[6] = '{10'h226, 10'h222, 10'h02E, 10'h32E, 10'h13E, 10'h23E};
   logic        clk, rst = 1'b1, wr = 1'b0, rd = 1'b0, seen;
   logic [3:0]  addr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, cnt, raw, d, raw_exp = 32'h0;
   wire         a, b, idx, gate;
   int          err_total = 0, checks_done = 0, sgn = 1, dl;
   qec_counter u_dut (.ref_clk_i(clk), .rst_i(rst), .enc_a_i(a), .enc_b_i(b), .enc_idx_i(idx),
      .enc_gate_i(gate), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .count_o(cnt), .raw_count_o(raw), .index_seen_o(seen));
   qec_enc_model u_enc (.ref_clk_i(clk), .a_o(a), .b_o(b), .idx_o(idx), .gate_o(gate));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wrt(logic [3:0] ad, logic [31:0] v);
      @(posedge clk);
      addr <= ad;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rdd(logic [3:0] ad);
      @(posedge clk);
      addr <= ad;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic rc(string n, logic [3:0] ad, logic [31:0] e);
      rdd(ad);
      chk(n, e, d);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rc("ctrl", 4'h0, 32'h40);
      foreach (rows[i]) begin
         wrt(4'h0, rows[i].c | 8'h01);
         wrt(4'h0, rows[i].c);
         if (rows[i].c[5]) u_enc.step(rows[i].dir[0], rows[i].n, rows[i].hi, rows[i].c[6] ? 20 : 8);
         else u_enc.quad(rows[i].dir, rows[i].n, rows[i].c[6] ? 20 : 8);
         // Which phase order counts up is the designer's pick, so row 0 fixes it.
         if (i == 0) rdd(4'h1);
         if (i == 0) sgn = d[31] ? -1 : 1;
         dl = rows[i].c[5] ? rows[i].e : sgn * rows[i].e;
         raw_exp += dl;
         rc("count", 4'h1, dl);
         chk("count port", dl, cnt);
         chk("raw port", raw_exp, raw);
         rc("raw", 4'h2, raw_exp);
         $display("row %0d done", i);
      end
      wrt(4'h0, 32'h61);
      u_enc.step(1'b1, 2, 20, 20);
      raw_exp += 2;
      rc("count", 4'h1, 0);
      rc("ctrl", 4'h0, 32'h61);
      foreach (ix[i]) begin
         wrt(4'h0, 32'h21);
         wrt(4'h0, 32'h20);
         u_enc.step(1'b1, 1, 8, 8);
         wrt(4'h0, ix[i][7:0]);
         u_enc.pulse(ix[i][8], 8);
         rc("count", 4'h1, !ix[i][9]);
         rc("ctrl", 4'h0, ix[i][9] ? ix[i][7:0] & 8'hFD : ix[i][7:0]);
         chk("seen", ix[i][9], seen);
         wrt(4'h3, 32'h1);
         raw_exp += 1;
         $display("index case %0d done", i);
      end
      rc("raw", 4'h2, raw_exp);
      u_enc.hold(40);
      rc("count", 4'h1, 32'h0);
      rc("status", 4'h3, 32'h2);
      $display("idle and status case done");
      rc("unmapped", 4'hF, 0);
      wrt(4'hF, 32'hFF);
      rc("ctrl", 4'h0, 32'h3C);
      finish_test();
   end
endmodule // qec_counter_test
`default_nettype wire

// File: bench/qec_enc_model.sv
// Encoder stand-in driving phase, index and gate lines.
// Assumes its tasks are entered just after a rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module qec_enc_model (
   input  wire logic ref_clk_i,
   output var  logic a_o = 1'b0,
   output var  logic b_o = 1'b0,
   output var  logic idx_o = 1'b0,
   output var  logic gate_o = 1'b0
);
   int ph = 0;
   task automatic hold(int n);
      repeat (n) @(posedge ref_clk_i);
   endtask
   // Gray order moves one phase line per step.
   task automatic quad(int dir, int n, int dw);
      repeat (n) begin
         ph = (ph + dir) & 3;
         a_o <= ph == 1 || ph == 2;
         b_o <= ph > 1;
         hold(dw);
      end
   endtask
   // Direction settles a full dwell before each step edge.
   task automatic step(logic up, int n, int hi, int dw);
      b_o <= up;
      repeat (n) begin
         hold(dw);
         a_o <= 1'b1;
         hold(hi);
         a_o <= 1'b0;
      end
      hold(dw);
   endtask
   task automatic pulse(logic g, int w);
      gate_o <= g;
      hold(w);
      idx_o <= 1'b1;
      hold(w);
      idx_o <= 1'b0;
      hold(w);
   endtask
endmodule // qec_enc_model
`default_nettype wire

// File: rtl/qec_consts.vh
// Constants for the quadrature encoder counter: register offsets, fields, timing.
// Assumes it is included by the counter module and nothing else.
`ifndef QEC_CONSTS_VH
`define QEC_CONSTS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define QEC_ADDR_CTRL      4'h0
`define QEC_ADDR_COUNT     4'h1
`define QEC_ADDR_RAW       4'h2
`define QEC_ADDR_STATUS    4'h3

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define QEC_CTRL_RESET     0
`define QEC_CTRL_ARM       1
`define QEC_CTRL_IDX_RISE  2
`define QEC_CTRL_GATE_EN   3
`define QEC_CTRL_GATE_INV  4
`define QEC_CTRL_STEPDIR   5
`define QEC_CTRL_FILTER    6
`define QEC_CTRL_RESET_VAL 8'h40

// ----------------------------------------------------------------------------
// Filter lengths in sample clocks
// ----------------------------------------------------------------------------
`define QEC_FILT_LONG      4'hF
`define QEC_FILT_SHORT     4'h3

`endif

// File: rtl/qec_counter.v
// Quadrature / step-direction encoder counter for one channel with index capture.
// Assumes ref_clk_i is the encoder sample clock and encoder pins are asynchronous.
// How it works
// - Channel takes A, B, index, plus an index-gating input when built with one.
// - While counter reset is set, adjusted count is held at zero.
// - Counter reset is never cleared by hardware; software clears it.
// - Armed index zeroes adjusted count on qualified index and clears the arm bit.
// - Running total counts since start-up, untouched by reset or index.
// - Edge bit one selects rising index edge, zero selects falling edge.
// - Gating enabled accepts index only at qualifying gate level; else ignored.
// - Gating polarity set needs gate low; clear needs gate high.
// - Mode bit zero selects quadrature; one makes A step and B direction.
// - Inputs register after 15 stable clocks filtered, 3 unfiltered.
// - Sampling and filtering run on the encoder sample clock.
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "qec_consts.vh"

module qec_counter #(
   parameter        HAS_GATE = 1,
   parameter        CW       = 32,
   parameter real   CLK_MHZ  = 100.0
) (
   // Clock and reset
   input  wire          ref_clk_i,
   input  wire          rst_i,
   // Encoder pins
   input  wire          enc_a_i,
   input  wire          enc_b_i,
   input  wire          enc_idx_i,
   input  wire          enc_gate_i,
   // Register port
   input  wire [3:0]    reg_addr_i,
   input  wire [31:0]   reg_wdata_i,
   input  wire          reg_wr_i,
   input  wire          reg_rd_i,
   output reg  [31:0]   reg_rdata_o,
   // Status
   output reg  [CW-1:0] count_o,
   output reg  [CW-1:0] raw_count_o,
   output wire          index_seen_o
);

   // -------------------------------------------------------------------------
   // Synchronisers
   // -------------------------------------------------------------------------
   // Two stages on every pin before the filter; the first stage feeds only
   // the second.
   reg  [3:0] sync1;
   reg  [3:0] sync2;
   wire [3:0] pins;

   assign pins = {(HAS_GATE != 0) ? enc_gate_i : 1'b1, enc_idx_i, enc_b_i, enc_a_i};

   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         sync1 <= 4'h0;
         sync2 <= 4'h0;
      end else begin
         sync1 <= pins;
         sync2 <= sync1;
      end
   end

   // -------------------------------------------------------------------------
   // Control register
   // -------------------------------------------------------------------------
   reg  [7:0] ctrl;
   reg        idx_seen;
   wire       idx_event;

   wire       cnt_reset = ctrl[`QEC_CTRL_RESET];
   wire       armed     = ctrl[`QEC_CTRL_ARM];
   wire       idx_rise  = ctrl[`QEC_CTRL_IDX_RISE];
   wire       gate_en   = ctrl[`QEC_CTRL_GATE_EN];
   wire       gate_inv  = ctrl[`QEC_CTRL_GATE_INV];
   wire       step_mode = ctrl[`QEC_CTRL_STEPDIR];
   wire       filt_on   = ctrl[`QEC_CTRL_FILTER];

   // -------------------------------------------------------------------------
   // Digital filters
   // -------------------------------------------------------------------------
   // One counter per line; a change is accepted only once it has held for the
   // whole window, so a shorter glitch restarts the count and is dropped.
   wire [3:0] filt_len = filt_on ? `QEC_FILT_LONG : `QEC_FILT_SHORT;
   reg  [3:0] filt_cnt [0:3];
   reg  [3:0] clean;
   integer    i;

   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         for (i = 0; i < 4; i = i + 1) begin
            filt_cnt[i] <= 4'h0;
         end
         clean <= 4'h0;
      end else begin
         for (i = 0; i < 4; i = i + 1) begin
            if (sync2[i] == clean[i]) begin
               filt_cnt[i] <= 4'h0;
            end else if (filt_cnt[i] >= filt_len - 4'h1) begin
               filt_cnt[i] <= 4'h0;
               clean[i]    <= sync2[i];
            end else begin
               filt_cnt[i] <= filt_cnt[i] + 4'h1;
            end
         end
      end
   end

   // -------------------------------------------------------------------------
   // Decoding
   // -------------------------------------------------------------------------
   reg  [3:0] prev;
   reg        step_up;
   reg        step_dn;

   // Edge finder shared by the step input and the index input.
   function edge_of;
      input now_lvl;
      input was_lvl;
      input want_rise;
      begin
         edge_of = want_rise ? (now_lvl && !was_lvl) : (!now_lvl && was_lvl);
      end
   endfunction

   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         prev <= 4'h0;
      end else begin
         prev <= clean;
      end
   end

   always @* begin
      step_up = 1'b0;
      step_dn = 1'b0;
      if (step_mode) begin
         if (edge_of(clean[0], prev[0], 1'b1)) begin
            step_up = clean[1];
            step_dn = !clean[1];
         end
      end else begin
         // Gray step forward: 00-01-11-10. A double change is ignored.
         case ({prev[1:0], clean[1:0]})
            4'b0001, 4'b0111, 4'b1110, 4'b1000: step_up = 1'b1;
            4'b0010, 4'b1011, 4'b1101, 4'b0100: step_dn = 1'b1;
            default: begin
               step_up = 1'b0;
               step_dn = 1'b0;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // Index qualification
   // -------------------------------------------------------------------------
   wire idx_edge = edge_of(clean[2], prev[2], idx_rise);
   wire gate_ok  = !gate_en || (gate_inv ? !clean[3] : clean[3]);

   assign idx_event    = armed && idx_edge && gate_ok;
   assign index_seen_o = idx_seen;

   // -------------------------------------------------------------------------
   // Counters
   // -------------------------------------------------------------------------
   wire [CW-1:0] delta = step_up ? {{(CW-1){1'b0}}, 1'b1} :
                         step_dn ? {CW{1'b1}} : {CW{1'b0}};

   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         count_o     <= {CW{1'b0}};
         raw_count_o <= {CW{1'b0}};
      end else begin
         raw_count_o <= raw_count_o + delta;
         if (cnt_reset || idx_event) begin
            count_o <= {CW{1'b0}};
         end else begin
            count_o <= count_o + delta;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Register port
   // -------------------------------------------------------------------------
   // The arm bit is cleared by the index event; an index in the same cycle as
   // a software write of arm wins, so the capture is never lost.
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         ctrl     <= `QEC_CTRL_RESET_VAL;
         idx_seen <= 1'b0;
      end else begin
         if (reg_wr_i && reg_addr_i == `QEC_ADDR_CTRL) begin
            ctrl <= reg_wdata_i[7:0];
         end
         if (reg_wr_i && reg_addr_i == `QEC_ADDR_STATUS && reg_wdata_i[0]) begin
            idx_seen <= 1'b0;
         end
         if (idx_event) begin
            ctrl[`QEC_CTRL_ARM] <= 1'b0;
            idx_seen            <= 1'b1;
         end
      end
   end

   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         reg_rdata_o <= 32'h0;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            `QEC_ADDR_CTRL:   reg_rdata_o <= {24'h0, ctrl};
            `QEC_ADDR_COUNT:  reg_rdata_o <= count_o;
            `QEC_ADDR_RAW:    reg_rdata_o <= raw_count_o;
            `QEC_ADDR_STATUS: reg_rdata_o <= {28'h0, clean};
            default:          reg_rdata_o <= 32'h0;
         endcase
      end else begin
         reg_rdata_o <= 32'h0;
      end
   end

endmodule // qec_counter

`default_nettype wire
